/* rtl/pin_sync3.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync3
    import spi_pkg::*;
#(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_val
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] val;
    } sync_s;

    sync_s            q;
    sync_s            d;
    logic [WIDTH-1:0] agreed;

    // A change counts only once stages two and three agree
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        assign agreed[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.val[i];
    end

    always_comb begin
        d     = q;
        d.s1  = pin_in;
        d.s2  = q.s1;
        d.s3  = q.s2;
        d.val = agreed;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pin_val = q.val;

endmodule

/* rtl/spi_pkg.sv */
// Shared constants, types and carriers of the serial port
package spi_pkg;

    localparam int unsigned WORD_BITS     = 8;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SCK_HALF_NS   = 80;
    // Least time: rounded up to whole cycles
    localparam logic [7:0]  SCK_HALF_CYC  =
        8'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Register offsets, byte addresses
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] DATA_OFS     = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
    localparam logic [7:0] STATE_OFS    = 8'h10;

    // Control register fields
    localparam int unsigned CTL_DONE_BIT    = 7;
    localparam int unsigned CTL_MASTER_BIT  = 6;
    localparam int unsigned CTL_FAULT_BIT   = 5;
    localparam int unsigned CTL_SEL_HI_BIT  = 3;
    localparam int unsigned CTL_SEL_LO_BIT  = 2;
    localparam int unsigned CTL_PORT_EN_BIT = 0;
    localparam logic [1:0]  SEL_RESET       = 2'h1;

    // Select modes
    localparam logic [1:0] SEL_3WIRE = 2'h0;
    localparam logic [1:0] SEL_4W_IN = 2'h1;

    // Interrupt status and mask fields
    localparam int unsigned IRQ_DONE_BIT  = 0;
    localparam int unsigned IRQ_FAULT_BIT = 1;
    localparam int unsigned IRQ_BITS      = 2;
    localparam logic [1:0]  IRQ_RESET     = 2'h0;

    // State register fields
    localparam int unsigned ST_BUSY_BIT   = 0;
    localparam int unsigned ST_SEL_BIT    = 1;
    localparam int unsigned ST_NSS_BIT    = 2;
    localparam int unsigned ST_COUNT_LSB  = 4;

    typedef enum logic [0:0] {
        XFER_IDLE,
        XFER_SHIFT
    } xfer_e;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic nss;
    } pins_in_s;

    typedef struct packed {
        logic sck_out;
        logic sck_oe_n;
        logic mosi_out;
        logic mosi_oe_n;
        logic miso_out;
        logic miso_oe_n;
        logic nss_out;
        logic nss_oe_n;
        logic nss_mapped;
    } pins_out_s;

endpackage

/* rtl/spi_port.sv */
// Serial port pin, select mode and transfer logic
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
//
// Overview of operation
// - Master drives the data-out line; slave only reads it.
// - Master reads the data-in line; slave drives it.
// - Words travel top bit first on both data lines.
// - As master the data-out line follows the shift register top bit.
// - Data-in line released when disabled or an unselected four-wire slave.
// - Three-wire slave drives its data line from the shift register top bit.
// - Master makes the serial clock; slave only samples it.
// - Unselected four-wire slave ignores all serial clock edges.
// - Select mode 00 is three-wire and ignores the select pin.
// - Three-wire slave always counts itself selected; sole slave on the bus.
// - Select mode 01 takes the select pin as input; low selects the slave.
// - Mode 01 master loses mastership on a falling select pin.
// - Upper select bit set drives the select pin at the lower bit level.
// - Select mode 00 (three-wire) leaves the select pin unmapped; modes 01, 10 and 11 map it.
// - Select mode bits sit at bits 3 and 2 of the control register.
// - Select fault clears master and port enables and sets the fault flag.
// - Four-wire slave restarts its bit counter on each falling select.
// - A transfer is complete after eight bits pass the shift register.
module spi_port
    import spi_pkg::*;
(
    input  wire logic     mclk,
    input  wire logic     rst_n,
    input  wire reg_req_s reg_req,
    output logic [31:0]   reg_rdata,
    output logic          irq,
    input  wire pins_in_s pins_in,
    output pins_out_s     pins_out
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic                master_en;
        logic                port_en;
        logic [1:0]          sel_mode;
        logic [IRQ_BITS-1:0] irq_stat;
        logic [IRQ_BITS-1:0] irq_mask;
        logic [31:0]         rdata;
        xfer_e               xfer;
        logic [7:0]          half_cnt;
        logic [2:0]          fall_cnt;
        logic                sck;
        logic                sck_prev;
        logic                nss_prev;
    } port_s;

    port_s      q;
    port_s      d;

    logic [3:0] pin_val;
    logic       sck_s;
    logic       mosi_s;
    logic       miso_s;
    logic       nss_s;

    logic       sh_clear;
    logic       sh_load;
    logic       sh_sample;
    logic       sh_shift;
    logic       sh_in;
    logic       sh_msb;
    logic [7:0] sh_rx;
    logic       sh_done;
    logic [2:0] sh_count;

    logic       selected;
    logic       slave_act;
    logic       master_act;
    logic       nss_fall;
    logic       sck_rise;
    logic       sck_fall;
    logic       fault;
    logic       wr_ctrl;
    logic       wr_data;
    logic       m_sample;
    logic       m_shift;

    ////////////////////////////////////////////////////////////////////////////
    // Pin inputs and shift register

    pin_sync3 #(
        .WIDTH (4)
    ) u_sync (
        .mclk    (mclk),
        .rst_n   (rst_n),
        // Select travels inverted: a zeroed synchroniser then reads idle high
        .pin_in  ({pins_in.sck, pins_in.mosi, pins_in.miso, !pins_in.nss}),
        .pin_val (pin_val)
    );

    assign sck_s  = pin_val[3];
    assign mosi_s = pin_val[2];
    assign miso_s = pin_val[1];
    assign nss_s  = !pin_val[0];

    spi_shifter u_shifter (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .clear     (sh_clear),
        .load      (sh_load),
        .load_byte (reg_req.wdata[7:0]),
        .sample    (sh_sample),
        .shift     (sh_shift),
        .in_bit    (sh_in),
        .msb       (sh_msb),
        .rx_byte   (sh_rx),
        .done      (sh_done),
        .bit_count (sh_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Select and edge decoding

    always_comb begin
        // Mode 00 ignores the pin; 1x is a master-only mode
        selected = (q.sel_mode == SEL_3WIRE) ||
                   (q.sel_mode == SEL_4W_IN && !nss_s);
        master_act = q.port_en && q.master_en;
        slave_act  = q.port_en && !q.master_en && selected;
        nss_fall   = q.nss_prev && !nss_s;
        sck_rise   = !q.sck_prev && sck_s;
        sck_fall   = q.sck_prev && !sck_s;
        fault      = master_act && q.sel_mode == SEL_4W_IN && nss_fall;
        wr_ctrl    = reg_req.wr && reg_req.addr == CTRL_OFS;
        wr_data    = reg_req.wr && reg_req.addr == DATA_OFS;
        m_sample   = q.xfer == XFER_SHIFT && q.half_cnt == SCK_HALF_CYC - 8'd1
                     && !q.sck;
        m_shift    = q.xfer == XFER_SHIFT && q.half_cnt == SCK_HALF_CYC - 8'd1
                     && q.sck;
    end

    // Slave clock is only an input; edges count only while selected
    assign sh_sample = master_act ? m_sample : (slave_act && sck_rise);
    assign sh_shift  = master_act ? m_shift : (slave_act && sck_fall);
    assign sh_in     = master_act ? miso_s : mosi_s;
    // Slave loads only between words so a live byte is never torn
    assign sh_load   = wr_data && q.port_en &&
                       (master_act ? q.xfer == XFER_IDLE : sh_count == 3'd0);
    assign sh_clear  = !q.port_en || fault ||
                       (!q.master_en && q.sel_mode == SEL_4W_IN && nss_fall);

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        d          = q;
        d.sck_prev = sck_s;
        d.nss_prev = nss_s;
        d.rdata    = '0;

        // Master clock generator
        if (master_act && q.xfer == XFER_SHIFT) begin
            if (q.half_cnt == SCK_HALF_CYC - 8'd1) begin
                d.half_cnt = '0;
                d.sck      = !q.sck;
                if (q.sck) begin
                    d.fall_cnt = q.fall_cnt + 3'd1;
                    if (q.fall_cnt == 3'(WORD_BITS - 1)) begin
                        d.xfer = XFER_IDLE;
                    end
                end
            end else begin
                d.half_cnt = q.half_cnt + 8'd1;
            end
        end else if (sh_load && master_act) begin
            d.xfer     = XFER_SHIFT;
            d.half_cnt = '0;
            d.fall_cnt = '0;
            d.sck      = 1'b0;
        end
        if (!master_act) begin
            d.xfer = XFER_IDLE;
            d.sck  = 1'b0;
        end

        // Register writes
        if (wr_ctrl) begin
            d.master_en = reg_req.wdata[CTL_MASTER_BIT];
            d.port_en   = reg_req.wdata[CTL_PORT_EN_BIT];
            d.sel_mode  = reg_req.wdata[CTL_SEL_HI_BIT:CTL_SEL_LO_BIT];
        end
        if (reg_req.wr && reg_req.addr == IRQ_MASK_OFS) begin
            d.irq_mask = reg_req.wdata[IRQ_BITS-1:0];
        end
        if (reg_req.wr && reg_req.addr == IRQ_STAT_OFS) begin
            d.irq_stat = q.irq_stat & ~reg_req.wdata[IRQ_BITS-1:0];
        end

        // Events set after the clear, so a set wins
        if (sh_done) begin
            d.irq_stat[IRQ_DONE_BIT] = 1'b1;
        end
        if (fault) begin
            d.master_en               = 1'b0;
            d.port_en                 = 1'b0;
            d.irq_stat[IRQ_FAULT_BIT] = 1'b1;
            d.xfer                    = XFER_IDLE;
            d.sck                     = 1'b0;
        end

        // Register reads; unmapped offsets read zero
        if (reg_req.rd) begin
            if (reg_req.addr == CTRL_OFS) begin
                d.rdata[CTL_DONE_BIT]                   = q.irq_stat[IRQ_DONE_BIT];
                d.rdata[CTL_MASTER_BIT]                 = q.master_en;
                d.rdata[CTL_FAULT_BIT]                  = q.irq_stat[IRQ_FAULT_BIT];
                d.rdata[CTL_SEL_HI_BIT:CTL_SEL_LO_BIT]  = q.sel_mode;
                d.rdata[CTL_PORT_EN_BIT]                = q.port_en;
            end else if (reg_req.addr == DATA_OFS) begin
                d.rdata[7:0] = sh_rx;
            end else if (reg_req.addr == IRQ_STAT_OFS) begin
                d.rdata[IRQ_BITS-1:0] = q.irq_stat;
            end else if (reg_req.addr == IRQ_MASK_OFS) begin
                d.rdata[IRQ_BITS-1:0] = q.irq_mask;
            end else if (reg_req.addr == STATE_OFS) begin
                d.rdata[ST_BUSY_BIT]                = q.xfer == XFER_SHIFT;
                d.rdata[ST_SEL_BIT]                 = selected;
                d.rdata[ST_NSS_BIT]                 = nss_s;
                d.rdata[ST_COUNT_LSB+2:ST_COUNT_LSB] = sh_count;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q          <= '0;
            q.sel_mode <= SEL_RESET;
            q.irq_stat <= IRQ_RESET;
            q.irq_mask <= IRQ_RESET;
            q.xfer     <= XFER_IDLE;
            q.sck_prev <= 1'b0;
            q.nss_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata = q.rdata;
    assign irq       = |(q.irq_stat & q.irq_mask);

    always_comb begin
        pins_out.sck_out    = q.sck;
        pins_out.sck_oe_n   = !master_act;
        pins_out.mosi_out   = sh_msb;
        pins_out.mosi_oe_n  = !master_act;
        pins_out.miso_out   = sh_msb;
        pins_out.miso_oe_n  = !slave_act;
        // Select output is honoured regardless of role
        pins_out.nss_out    = q.sel_mode[0];
        pins_out.nss_oe_n   = !q.sel_mode[1];
        pins_out.nss_mapped = q.sel_mode != SEL_3WIRE;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_ctrl_wr(logic m, logic e, logic [1:0] s);
        wr_ctrl && reg_req.wdata[CTL_MASTER_BIT] == m &&
        reg_req.wdata[CTL_PORT_EN_BIT] == e &&
        reg_req.wdata[CTL_SEL_HI_BIT:CTL_SEL_LO_BIT] == s;
    endsequence

    sequence s_quiet;
        !fault [*1];
    endsequence

    a_master_dirs: assert property (
        s_ctrl_wr(1'b1, 1'b1, SEL_3WIRE) ##1 s_quiet |->
        !pins_out.mosi_oe_n && pins_out.miso_oe_n && !pins_out.sck_oe_n)
        else $error("master did not drive data-out and clock");

    a_slave_dirs: assert property (
        s_ctrl_wr(1'b0, 1'b1, SEL_3WIRE) |=>
        !pins_out.miso_oe_n && pins_out.mosi_oe_n && pins_out.sck_oe_n)
        else $error("three-wire slave did not drive data-in line");

    a_miso_released: assert property (
        (!q.port_en || (!q.master_en && q.sel_mode == SEL_4W_IN && nss_s))
        |-> pins_out.miso_oe_n)
        else $error("data-in line driven while disabled or deselected");

    a_start_msb: assert property (
        (sh_load && master_act) |=> pins_out.mosi_out == $past(reg_req.wdata[7])
        && q.xfer == XFER_SHIFT)
        else $error("master start did not present the top bit");

    a_deselect_ignores: assert property (
        (q.port_en && !q.master_en && q.sel_mode == SEL_4W_IN && nss_s
         && $stable(nss_s) && !sh_load) |=> $stable(sh_count))
        else $error("deselected slave counted a clock edge");

    a_fault_disables: assert property (
        fault |=> !q.master_en && !q.port_en && q.irq_stat[IRQ_FAULT_BIT]
        ##1 pins_out.mosi_oe_n)
        else $error("select fault did not drop mastership");

    a_count_restart: assert property (
        (q.port_en && !q.master_en && q.sel_mode == SEL_4W_IN && nss_fall)
        |=> sh_count == 3'd0)
        else $error("falling select did not restart bit count");

    a_select_out: assert property (
        wr_ctrl && reg_req.wdata[CTL_SEL_HI_BIT] |=>
        !pins_out.nss_oe_n && pins_out.nss_out == $past(reg_req.wdata[CTL_SEL_LO_BIT]))
        else $error("select output level wrong");

    a_pin_mapping: assert property (
        wr_ctrl |=> pins_out.nss_mapped ==
        ($past(reg_req.wdata[CTL_SEL_HI_BIT:CTL_SEL_LO_BIT]) != SEL_3WIRE))
        else $error("select pin mapping wrong");

    a_word_length: assert property (
        (sh_load && master_act) ##1 (master_act && !sh_load) [*8] |->
        q.xfer == XFER_SHIFT)
        else $error("master transfer ended early");

endmodule

/* rtl/spi_shifter.sv */
// Eight-bit shift register with bit counter
`timescale 1ns/10ps
module spi_shifter
    import spi_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       clear,
    input  wire logic       load,
    input  wire logic [7:0] load_byte,
    input  wire logic       sample,
    input  wire logic       shift,
    input  wire logic       in_bit,
    output logic            msb,
    output logic [7:0]      rx_byte,
    output logic            done,
    output logic [2:0]      bit_count
);

    typedef struct packed {
        logic [7:0] sh;
        logic [7:0] rx;
        logic [2:0] cnt;
        logic       held;
        logic       done;
    } shifter_s;

    shifter_s q;
    shifter_s d;

    always_comb begin
        d      = q;
        d.done = 1'b0;
        if (load) begin
            d.sh = load_byte;
        end else if (sample) begin
            d.held = in_bit;
            // An abandoned word raises no done
            if (q.cnt == 3'(WORD_BITS - 1) && !clear) begin
                d.done = 1'b1;
                d.rx   = {q.sh[6:0], in_bit};
                d.cnt  = '0;
            end else begin
                d.cnt = q.cnt + 3'd1;
            end
        end else if (shift) begin
            // Left shift keeps the top bit on the line first
            d.sh = {q.sh[6:0], q.held};
        end
        if (clear) begin
            d.cnt = '0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign msb       = q.sh[7];
    assign rx_byte   = q.rx;
    assign done      = q.done;
    assign bit_count = q.cnt;

    a_done_eighth: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $rose(done) |-> $past(sample) && $past(q.cnt) == 3'd7 && $past(!clear))
        else $error("done without an eighth sampled bit");

    a_msb_first: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (shift && !load) |=> msb == $past(q.sh[6]))
        else $error("shift did not move the next lower bit to the top");

endmodule

/* tb/far_side.sv */
// Far-side serial device: answers as slave, clocks as master
`timescale 1ns/10ps
module far_side (
    input  wire logic  sck_line,
    input  wire logic  mosi_line,
    input  wire logic  miso_line,
    output logic       sck_val,
    output logic       mosi_val,
    output logic       miso_val,
    output logic       nss_val,
    output logic [7:0] rx_q
);
    logic       slave_on;
    logic [7:0] sh;

    initial begin
        sck_val  = 1'b0;
        mosi_val = 1'b0;
        miso_val = 1'b0;
        nss_val  = 1'b1;
        slave_on = 1'b0;
        sh       = 8'h00;
        rx_q     = 8'h00;
    end
    ////////////////////////////////////////
    // Slave role: sample on rise, next bit on fall
    task automatic arm(input logic [7:0] b);
        sh       = b;
        rx_q     = 8'h00;
        slave_on = 1'b1;
        miso_val = b[7];
    endtask
    // Released line must not keep showing the last bit
    task automatic disarm();
        slave_on = 1'b0;
        miso_val = ~miso_val;
    endtask
    always @(posedge sck_line) begin
        if (slave_on) begin
            rx_q <= {rx_q[6:0], mosi_line};
        end
    end
    always @(negedge sck_line) begin
        if (slave_on) begin
            sh       = {sh[6:0], 1'b0};
            miso_val = sh[7];
        end
    end
    ////////////////////////////////////////
    // Master role: clock only inside the frame, idle low
    task automatic xfer(input logic [7:0] tx, input int nbits, input bit use_nss,
                        output logic [7:0] rx);
        logic [7:0] t;
        t  = tx;
        rx = 8'h00;
        #3;
        if (use_nss) begin
            nss_val = 1'b0;
        end
        mosi_val = t[7];
        #160;
        for (int i = 0; i < nbits; i++) begin
            #80 sck_val = 1'b1;
            rx = {rx[6:0], miso_line};
            #80 sck_val = 1'b0;
            t = t << 1;
            mosi_val = t[7];
        end
        #80;
        nss_val  = 1'b1;
        mosi_val = ~mosi_val;
        #160;
    endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench of the serial port against a far-side model
`timescale 1ns/10ps
module testbench
    import spi_pkg::*;
;
    logic        mclk;
    logic        rst_n;
    reg_req_s    req;
    logic [31:0] rdata;
    logic        irq;
    pins_out_s   po;
    pins_in_s    pin;
    logic        f_sck, f_mosi, f_miso, f_nss;
    logic        sck_l, mosi_l, miso_l, nss_l;
    logic [7:0]  tx, stx, got;
    logic [7:0]  exp_q[$];
    int          fail_count, checks, m;

    assign sck_l  = po.sck_oe_n ? f_sck : po.sck_out;
    assign mosi_l = po.mosi_oe_n ? f_mosi : po.mosi_out;
    assign miso_l = po.miso_oe_n ? f_miso : po.miso_out;
    assign nss_l  = po.nss_oe_n ? f_nss : po.nss_out;
    assign pin    = {sck_l, mosi_l, miso_l, nss_l};

    spi_port i_spi_port (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .reg_req  (req),
        .reg_rdata(rdata),
        .irq      (irq),
        .pins_in  (pin),
        .pins_out (po)
    );
    far_side i_far_side (
        .sck_line (sck_l),
        .mosi_line(mosi_l),
        .miso_line(miso_l),
        .sck_val  (f_sck),
        .mosi_val (f_mosi),
        .miso_val (f_miso),
        .nss_val  (f_nss),
        .rx_q     ()
    );
    ////////////////////////////////////////
    task automatic final_report();
        if (fail_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge mclk);
        req.wr <= 1'b0;
        #1;
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge mclk);
        req.rd <= 1'b0;
        #1;
        check(rdata, e);
    endtask
    // Level output may trail its cause by a register stage
    task automatic expect_irq(input logic e);
        @(posedge mclk);
        #1;
        check(32'(irq), 32'(e));
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 600) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 600) begin
            fail_count++;
            final_report();
        end
    endtask
    ////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        rst_n      = 1'b0;
        req        = '0;
        fail_count = 0;
        checks     = 0;
        void'($urandom(32'h2326));
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        check(32'({po.sck_oe_n, po.mosi_oe_n, po.miso_oe_n, po.nss_mapped}), 32'hF);
        expect_reg(CTRL_OFS, 32'h0000_0004);
        expect_reg(IRQ_STAT_OFS, 32'h0000_0000);
        reg_wr(8'h14, 32'hFFFF_FFFF);
        expect_reg(8'h14, 32'h0000_0000);
        // Master in every select mode but 01
        reg_wr(IRQ_MASK_OFS, 32'h0000_0001);
        for (m = 0; m < 4; m++) begin
            if (m == 1) begin
                continue;
            end
            // Select output modes are only ever chosen here, with the port as master
            reg_wr(CTRL_OFS, 32'(8'h41 | (m << 2)));
            check(32'({po.nss_mapped, po.nss_oe_n}), 32'({m != 0, m < 2}));
            if (m >= 2) begin
                check(32'(po.nss_out), 32'(m & 1));
            end
            tx  = 8'($urandom);
            stx = 8'($urandom);
            exp_q.push_back(stx);
            i_far_side.arm(stx);
            reg_wr(DATA_OFS, 32'(tx));
            reg_wr(DATA_OFS, 32'(~tx));
            check(32'({po.mosi_oe_n, po.miso_oe_n, po.sck_oe_n}), 32'h2);
            wait_irq();
            repeat (20) @(posedge mclk);
            i_far_side.disarm();
            check(32'(i_far_side.rx_q), 32'(tx));
            expect_reg(DATA_OFS, 32'(exp_q.pop_front()));
            expect_reg(IRQ_STAT_OFS, 32'h0000_0001);
            reg_wr(IRQ_STAT_OFS, 32'h0000_0001);
            expect_irq(1'b0);
        end
        // Falling select while multi-master: fault, masked then unmasked
        reg_wr(IRQ_MASK_OFS, 32'h0000_0000);
        reg_wr(CTRL_OFS, 32'h0000_0045);
        i_far_side.nss_val = 1'b0;
        repeat (10) @(posedge mclk);
        expect_irq(1'b0);
        expect_reg(CTRL_OFS, 32'h0000_0024);
        expect_reg(IRQ_STAT_OFS, 32'h0000_0002);
        check(32'({po.sck_oe_n, po.mosi_oe_n}), 32'h3);
        reg_wr(IRQ_MASK_OFS, 32'h0000_0002);
        expect_irq(1'b1);
        reg_wr(IRQ_STAT_OFS, 32'h0000_0002);
        expect_irq(1'b0);
        i_far_side.nss_val = 1'b1;
        repeat (10) @(posedge mclk);
        // Four-wire slave: clocks ignored while deselected
        reg_wr(CTRL_OFS, 32'h0000_0005);
        tx = 8'($urandom);
        reg_wr(DATA_OFS, 32'(tx));
        check(32'({po.miso_oe_n, po.mosi_oe_n}), 32'h3);
        i_far_side.xfer(8'($urandom), 8, 1'b0, got);
        expect_reg(STATE_OFS, 32'h0000_0004);
        expect_reg(IRQ_STAT_OFS, 32'h0000_0000);
        stx = 8'($urandom);
        exp_q.push_back(stx);
        fork
            i_far_side.xfer(stx, 8, 1'b1, got);
            begin
                repeat (30) @(posedge mclk);
                #1;
                check(32'({po.miso_oe_n, po.mosi_oe_n}), 32'h1);
            end
        join
        check(32'(got), 32'(tx));
        expect_reg(DATA_OFS, 32'(exp_q.pop_front()));
        reg_wr(IRQ_STAT_OFS, 32'h0000_0001);
        // Partial frame then full frame: count restarts on falling select
        i_far_side.xfer(8'($urandom), 3, 1'b1, got);
        stx = 8'($urandom);
        i_far_side.xfer(stx, 8, 1'b1, got);
        expect_reg(DATA_OFS, 32'(stx));
        reg_wr(IRQ_STAT_OFS, 32'h0000_0001);
        // Three-wire slave: always selected, select pin unmapped
        reg_wr(CTRL_OFS, 32'h0000_0001);
        tx = 8'($urandom);
        reg_wr(DATA_OFS, 32'(tx));
        check(32'({po.miso_oe_n, po.nss_mapped, po.miso_out}), 32'(tx[7]));
        stx = 8'($urandom);
        i_far_side.xfer(stx, 8, 1'b0, got);
        check(32'(got), 32'(tx));
        expect_reg(DATA_OFS, 32'(stx));
        // Disabled port releases its lines
        reg_wr(CTRL_OFS, 32'h0000_0000);
        check(32'({po.miso_oe_n, po.mosi_oe_n, po.sck_oe_n}), 32'h7);
        final_report();
    end
endmodule
